// ---- verilog/cpu_interrupt_controller.sv ----
// Interrupt controller of the core: flags, enables, priority, nesting
// Assumes a sequencer giving machine-cycle and instruction-end strobes
`timescale 1ns/1ps
`include "irq_ctrl_regs.svh"

// Behaviour
// - Eleven request sources arbitrated over four priority levels.
// - Pending enabled request starts forced call at next instruction end.
// - Only a strictly higher level preempts a running service.
// - Return instruction ends the highest active service level.
// - Flags set by hardware whether or not the source is enabled.
// - Flags sampled once per machine cycle, samples then polled.
// - Detect one machine cycle, forced call six, entry at seven.
// - Global enable bit clear blocks every source.
// - First enable register holds ext0, timer0, ext1, timer1, serial0.
// - Second enable register holds ext2 to ext6 at bits 1 to 5.
// - Third enable register bit 0 enables serial one.
// - Ext0 and ext1 edge flags set on falling edge, cleared on vector.
// - Type bits choose falling edge (one) or low level (zero).
// - Timer overflow flags sit at control bits 7 and 5.
// - Polarity bits pick negative (zero) or positive edge for ext2/3.
// - Request register holds ext2 to ext6 flags at bits 1 to 5.
// - Masked peripheral sources of one input are ORed together.
// - Ext0/1 from user I/O groups, ext2/3 from dedicated pins.
// - Ext4 to ext6 rising-edge sensitive after source conversion.
// - Grouped per-source flags clear on read; software saves the value.
// - Core request flag cleared by hardware when vectored.
// - All SFR registers reset to zero; previous pin levels reset high.
// - Group level from one bit of each priority register, 0 to 3.
// - Fixed vector address per source.
// - Same level ties resolved by fixed polling order.
module cpu_interrupt_controller (
	input  wire logic        clk_i,          // Core clock
	input  wire logic        rst_i,          // Sync reset, active high
	input  wire logic [7:0]  sfr_addr_i,     // SFR address
	input  wire logic [7:0]  sfr_wdata_i,    // SFR write data
	input  wire logic        sfr_wr_i,       // SFR write strobe
	input  wire logic        sfr_rd_i,       // SFR read strobe
	output logic      [7:0]  sfr_rdata_o,    // SFR read data, next cycle
	input  wire logic        mcycle_i,       // Machine-cycle strobe
	input  wire logic        instr_end_i,    // Instruction boundary
	input  wire logic        return_from_irq_instr_i, // Return executed
	input  wire logic        user_io_hi_n_i, // User I/O high group, low act
	input  wire logic        user_io_lo_n_i, // User I/O low group, low act
	input  wire logic        irq_pin_a_i,    // Dedicated pin, ext two
	input  wire logic        irq_pin_b_i,    // Dedicated pin, ext three
	input  wire logic [3:0]  ext4_src_i,     // Smart card sources
	input  wire logic [3:0]  ext4_mask_i,    // Their masks
	input  wire logic [3:0]  ext5_src_i,     // Keypad sources
	input  wire logic [3:0]  ext5_mask_i,    // Their masks
	input  wire logic [3:0]  ext6_src_i,     // Bus, fault, comparator
	input  wire logic [3:0]  ext6_mask_i,    // Their masks
	input  wire logic        t0_ovf_i,       // Timer 0 overflow pulse
	input  wire logic        t1_ovf_i,       // Timer 1 overflow pulse
	input  wire logic        s0_req_i,       // Serial 0 request level
	input  wire logic        s1_req_i,       // Serial 1 request level
	output logic             force_call_o,   // Forced long call in progress
	output logic             vector_entry_o, // Pulse: handler entered
	output logic      [15:0] vector_o,       // Vector of call
	output logic      [3:0]  in_service_o    // Active service levels
);
	// ------------------------------------------------------------------
	// Registers and state
	// ------------------------------------------------------------------
	logic [7:0]                 en_first;
	logic [7:0]                 en_second;
	logic [7:0]                 en_third;
	logic [7:0]                 timer_irq_control;
	logic [7:0]                 req_flags;
	logic [7:0]                 edge_pol;
	logic [7:0]                 prio_lo;
	logic [7:0]                 prio_hi;
	logic [3:0]                 pin_prev;
	logic [2:0]                 grp_prev;
	logic [`NUM_SRC-1:0]        sample;
	logic [`NUM_SRC-1:0]        raw_req;
	logic [`NUM_SRC-1:0]        src_en;
	logic [`NUM_SRC-1:0]        ack_clr;
	logic [3:0]                 in_service;
	logic [2:0]                 call_cnt;
	irq_ctrl_pkg::call_state_e  state;
	irq_ctrl_pkg::irq_call_s    call;
	irq_ctrl_pkg::irq_call_s    next_call;
	logic                       win_valid;
	logic                       take;
	logic [2:0]                 grp_now;
	logic [3:0]                 pin_now;
	logic [3:0]                 pin_fall;
	logic [2:0]                 grp_rise;
	logic                       wr_timer_irq_control;
	logic                       wr_req;

	// Pins seen only at machine-cycle boundaries
	// user I/O and pins
	assign pin_now = {irq_pin_b_i, irq_pin_a_i, user_io_lo_n_i,
		user_io_hi_n_i};
	// outside clear-on-read
	// Per-source flags live beside the peripherals; only their OR comes in
	// grouped OR
	assign grp_now = {|(ext6_src_i & ext6_mask_i),
		|(ext5_src_i & ext5_mask_i), |(ext4_src_i & ext4_mask_i)};
	assign pin_fall = {
		edge_pol[`BIT_EXT3_POL] ? (~pin_prev[3] & pin_now[3])
			: (pin_prev[3] & ~pin_now[3]),
		edge_pol[`BIT_EXT2_POL] ? (~pin_prev[2] & pin_now[2])
			: (pin_prev[2] & ~pin_now[2]),
		pin_prev[1] & ~pin_now[1],
		pin_prev[0] & ~pin_now[0]};
	assign grp_rise = ~grp_prev & grp_now;
	assign wr_timer_irq_control = sfr_wr_i && (sfr_addr_i == `OFS_TIMER_IRQ_CONTROL);
	assign wr_req = sfr_wr_i && (sfr_addr_i == `OFS_IRQ_REQUEST_FLAGS);

	// Previous pin and group levels, taken each machine cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pin_prev <= 4'hF;
			grp_prev <= 3'h0;
		end
		else if (mcycle_i)
		begin
			pin_prev <= pin_now;
			grp_prev <= grp_now;
		end
	end

	// ------------------------------------------------------------------
	// Plain read/write registers
	// ------------------------------------------------------------------
	// zero reset
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			en_first  <= `REG_RESET;
			en_second <= `REG_RESET;
			en_third  <= `REG_RESET;
			edge_pol  <= `REG_RESET;
			prio_lo   <= `REG_RESET;
			prio_hi   <= `REG_RESET;
		end
		else if (sfr_wr_i)
		begin
			if (sfr_addr_i == `OFS_IRQ_ENABLE_FIRST)
				en_first <= sfr_wdata_i & `MASK_EN_FIRST;
			else if (sfr_addr_i == `OFS_IRQ_ENABLE_SECOND)
				en_second <= sfr_wdata_i & `MASK_EN_SECOND;
			else if (sfr_addr_i == `OFS_IRQ_ENABLE_THIRD)
				en_third <= sfr_wdata_i & `MASK_EN_THIRD;
			else if (sfr_addr_i == `OFS_EDGE_POL_CONTROL)
				edge_pol <= sfr_wdata_i & `MASK_EDGE_POL;
			else if (sfr_addr_i == `OFS_PRIORITY_LOW_BITS)
				prio_lo <= sfr_wdata_i & `MASK_PRIORITY;
			else if (sfr_addr_i == `OFS_PRIORITY_HIGH_BITS)
				prio_hi <= sfr_wdata_i & `MASK_PRIORITY;
		end
	end

	// ------------------------------------------------------------------
	// Request flags; hardware set beats software or vector clear
	// ------------------------------------------------------------------
	// flag set
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			timer_irq_control <= `REG_RESET;
		else
		begin
			if (wr_timer_irq_control)
				timer_irq_control <= sfr_wdata_i & `MASK_TIMER_CTL;
			if (ack_clr[`SRC_EX0])
				timer_irq_control[`BIT_EXT0_FLAG] <= 1'b0;
			if (ack_clr[`SRC_EX1])
				timer_irq_control[`BIT_EXT1_FLAG] <= 1'b0;
			if (ack_clr[`SRC_T0])
				timer_irq_control[`BIT_T0_FLAG] <= 1'b0;
			if (ack_clr[`SRC_T1])
				timer_irq_control[`BIT_T1_FLAG] <= 1'b0;
			if (t0_ovf_i)
				timer_irq_control[`BIT_T0_FLAG] <= 1'b1;
			if (t1_ovf_i)
				timer_irq_control[`BIT_T1_FLAG] <= 1'b1;
			if (mcycle_i)
			begin
				if (timer_irq_control[`BIT_EXT0_TYPE])
				begin
					if (pin_fall[0])
						timer_irq_control[`BIT_EXT0_FLAG] <= 1'b1;
				end
				else
					timer_irq_control[`BIT_EXT0_FLAG] <= ~pin_now[0];
				if (timer_irq_control[`BIT_EXT1_TYPE])
				begin
					if (pin_fall[1])
						timer_irq_control[`BIT_EXT1_FLAG] <= 1'b1;
				end
				else
					timer_irq_control[`BIT_EXT1_FLAG] <= ~pin_now[1];
			end
		end
	end

	// Grouped sources keep their own flags; only the edge is stored here
	// ext2-6 flags
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			req_flags <= `REG_RESET;
		else
		begin
			if (wr_req)
				req_flags <= sfr_wdata_i & `MASK_REQ_FLAGS;
			for (int i = 0; i < 5; i++)
			begin
				// Ext2/3 sit apart in polling order, ext4 to 6 follow
				if (ack_clr[(i < 2) ? `SRC_EX2 + 2*i : `SRC_EX4 + i - 2])
					req_flags[`BIT_EXT2_REQ + i] <= 1'b0;
			end
			if (mcycle_i)
			begin
				if (pin_fall[2])
					req_flags[`BIT_EXT2_REQ] <= 1'b1;
				if (pin_fall[3])
					req_flags[`BIT_EXT2_REQ + 1] <= 1'b1;
				for (int g = 0; g < 3; g++)
				begin
					if (grp_rise[g])
						req_flags[`BIT_EXT2_REQ + 2 + g] <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Sampling and priority polling
	// ------------------------------------------------------------------
	// Raw requests and enables in polling order
	// enable map
	always_comb
	begin
		raw_req = {req_flags[5], req_flags[4], req_flags[3], s0_req_i,
			timer_irq_control[`BIT_T1_FLAG], req_flags[2],
			timer_irq_control[`BIT_EXT1_FLAG], req_flags[1],
			timer_irq_control[`BIT_T0_FLAG], s1_req_i,
			timer_irq_control[`BIT_EXT0_FLAG]};
		src_en = {en_second[5], en_second[4], en_second[3],
			en_first[`BIT_S0_EN], en_first[`BIT_T1_EN], en_second[2],
			en_first[`BIT_EXT1_EN], en_second[1], en_first[`BIT_T0_EN],
			en_third[`BIT_S1_EN], en_first[`BIT_EXT0_EN]};
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			sample <= '0;
		else if (mcycle_i)
			sample <= raw_req & ~ack_clr;
	end

	// Highest level wins, ties go to the earliest polling index
	// arbitration
	always_comb
	begin
		logic [1:0] lvl;
		logic       elig;
		lvl = 2'h0;
		elig = 1'b0;
		win_valid = 1'b0;
		next_call = '0;
		for (int i = `NUM_SRC - 1; i >= 0; i--)
		begin
			lvl = {prio_hi[irq_ctrl_pkg::GROUP_T[i]],
				prio_lo[irq_ctrl_pkg::GROUP_T[i]]};
			elig = sample[i] && src_en[i] && en_first[`BIT_GLOBAL_EN];
			if (elig && (!win_valid || lvl >= next_call.level))
			begin
				win_valid = 1'b1;
				next_call.level = lvl;
				next_call.src = 4'(i);
				next_call.vector = irq_ctrl_pkg::VECTOR_T[i];
			end
		end
	end

	always_comb
	begin
		take = win_valid && mcycle_i && instr_end_i
			&& (state == irq_ctrl_pkg::ST_IDLE)
			&& ((in_service >> next_call.level) == 4'h0);
	end

	// Clearing acts on the cycle the call is taken
	always_comb
	begin
		ack_clr = '0;
		if (take)
			ack_clr[next_call.src] = 1'b1;
	end

	// ------------------------------------------------------------------
	// Forced call sequencer and service nesting
	// ------------------------------------------------------------------
	// forced call
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state <= irq_ctrl_pkg::ST_IDLE;
			call <= '0;
			call_cnt <= 3'h0;
			vector_entry_o <= 1'b0;
		end
		else
		begin
			vector_entry_o <= 1'b0;
			case (state)
				irq_ctrl_pkg::ST_IDLE:
					if (take)
					begin
						state <= irq_ctrl_pkg::ST_CALL;
						call <= next_call;
						call_cnt <= 3'h0;
					end
				irq_ctrl_pkg::ST_CALL:
					if (mcycle_i)
					begin
						call_cnt <= call_cnt + 3'h1;
						if (call_cnt == `CALL_MCYCLES - 3'h1)
						begin
							state <= irq_ctrl_pkg::ST_IDLE;
							vector_entry_o <= 1'b1;
						end
					end
				default:
					state <= irq_ctrl_pkg::ST_IDLE;
			endcase
		end
	end

	// Service levels; return clears the highest one still active
	// return clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			in_service <= 4'h0;
		else
		begin
			if (return_from_irq_instr_i)
			begin
				if (in_service[3])
					in_service[3] <= 1'b0;
				else if (in_service[2])
					in_service[2] <= 1'b0;
				else if (in_service[1])
					in_service[1] <= 1'b0;
				else
					in_service[0] <= 1'b0;
			end
			if (take)
				in_service[next_call.level] <= 1'b1;
		end
	end

	// Outputs straight from flip-flops
	assign force_call_o = state[1];
	assign vector_o = call.vector;
	assign in_service_o = in_service;

	// SFR read data, registered; unmapped addresses read zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			sfr_rdata_o <= 8'h00;
		else if (!sfr_rd_i)
			sfr_rdata_o <= 8'h00;
		else if (sfr_addr_i == `OFS_TIMER_IRQ_CONTROL)
			sfr_rdata_o <= timer_irq_control;
		else if (sfr_addr_i == `OFS_IRQ_REQUEST_FLAGS)
			sfr_rdata_o <= req_flags;
		else if (sfr_addr_i == `OFS_IRQ_ENABLE_FIRST)
			sfr_rdata_o <= en_first;
		else if (sfr_addr_i == `OFS_IRQ_ENABLE_SECOND)
			sfr_rdata_o <= en_second;
		else if (sfr_addr_i == `OFS_IRQ_ENABLE_THIRD)
			sfr_rdata_o <= en_third;
		else if (sfr_addr_i == `OFS_EDGE_POL_CONTROL)
			sfr_rdata_o <= edge_pol;
		else if (sfr_addr_i == `OFS_PRIORITY_LOW_BITS)
			sfr_rdata_o <= prio_lo;
		else if (sfr_addr_i == `OFS_PRIORITY_HIGH_BITS)
			sfr_rdata_o <= prio_hi;
		else
			sfr_rdata_o <= 8'h00;
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	global_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!en_first[`BIT_GLOBAL_EN] |-> !take)
		else $error("call taken with global enable clear");
	strict_preempt_a: assert property (@(posedge clk_i) disable iff (rst_i)
		take |-> !in_service[next_call.level])
		else $error("equal level preempted service");
	call_enter_a: assert property (@(posedge clk_i) disable iff (rst_i)
		take |=> force_call_o && vector_o == $past(next_call.vector))
		else $error("forced call not started with vector");
	entry_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
		vector_entry_o |-> call_cnt == `CALL_MCYCLES && !force_call_o)
		else $error("entry not after six machine cycles");
	vector_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		take && next_call.src == `SRC_T0 && !t0_ovf_i
		|=> !timer_irq_control[`BIT_T0_FLAG])
		else $error("timer 0 flag not cleared on vector");
	timer_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		t1_ovf_i |=> timer_irq_control[`BIT_T1_FLAG])
		else $error("timer 1 flag not set");
	return_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
		return_from_irq_instr_i && !take && in_service[3] |=> !in_service[3]
		&& in_service[2:0] == $past(in_service[2:0]))
		else $error("return cleared wrong level");
	sample_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!mcycle_i |=> $stable(sample))
		else $error("sample changed between machine cycles");
	rise_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
		mcycle_i && grp_rise[0] |=> req_flags[3])
		else $error("ext4 rising edge not flagged");
endmodule // cpu_interrupt_controller

// ---- verilog/irq_ctrl_regs.svh ----
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by the interrupt controller package and module only
`ifndef IRQ_CTRL_REGS_SVH
`define IRQ_CTRL_REGS_SVH
// ----------------------------------------------------------------------
// Register offsets on the special function register port
// ----------------------------------------------------------------------
`define OFS_TIMER_IRQ_CONTROL  8'h88
`define OFS_IRQ_ENABLE_THIRD   8'h9A
`define OFS_IRQ_ENABLE_FIRST   8'hA8
`define OFS_PRIORITY_LOW_BITS  8'hA9
`define OFS_IRQ_ENABLE_SECOND  8'hB8
`define OFS_PRIORITY_HIGH_BITS 8'hB9
`define OFS_IRQ_REQUEST_FLAGS  8'hC0
`define OFS_EDGE_POL_CONTROL   8'hC8
`define REG_RESET              8'h00
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_GLOBAL_EN   7
`define BIT_EXT0_EN     0
`define BIT_T0_EN       1
`define BIT_EXT1_EN     2
`define BIT_T1_EN       3
`define BIT_S0_EN       4
`define BIT_S1_EN       0
`define BIT_EXT0_TYPE   0
`define BIT_EXT0_FLAG   1
`define BIT_EXT1_TYPE   2
`define BIT_EXT1_FLAG   3
`define BIT_T0_FLAG     5
`define BIT_T1_FLAG     7
`define BIT_EXT2_POL    5
`define BIT_EXT3_POL    6
`define BIT_EXT2_REQ    1
`define MASK_EN_FIRST   8'h9F
`define MASK_EN_SECOND  8'h3E
`define MASK_EN_THIRD   8'h01
`define MASK_TIMER_CTL  8'hFF
`define MASK_REQ_FLAGS  8'h3E
`define MASK_EDGE_POL   8'h60
`define MASK_PRIORITY   8'h3F
// ----------------------------------------------------------------------
// Polling order, source indices and timing
// ----------------------------------------------------------------------
`define NUM_SRC         11
`define NUM_GROUP       6
`define SRC_EX0         0
`define SRC_S1          1
`define SRC_T0          2
`define SRC_EX2         3
`define SRC_EX1         4
`define SRC_EX3         5
`define SRC_T1          6
`define SRC_S0          7
`define SRC_EX4         8
`define SRC_EX5         9
`define SRC_EX6         10
`define CALL_MCYCLES    3'h6
`define GROUP_WIDTH     4
`endif

// ---- verilog/irq_ctrl_pkg.sv ----
// Types shared by the interrupt controller
// Assumes irq_ctrl_regs.svh is on the include path
package irq_ctrl_pkg;
	// Call sequencer states, one-hot
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_CALL = 2'b10
	} call_state_e;

	// Forced call being issued to the core
	typedef struct packed {
		logic [15:0] vector;
		logic [1:0]  level;
		logic [3:0]  src;
	} irq_call_s;

	// Vector per polling index
	localparam logic [15:0] VECTOR_T [0:10] = '{
		16'h0003, 16'h0083, 16'h000B, 16'h004B, 16'h0013, 16'h0053,
		16'h001B, 16'h0023, 16'h005B, 16'h0063, 16'h006B};
	// Priority group per polling index
	localparam logic [2:0] GROUP_T [0:10] = '{
		3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h3, 3'h4, 3'h5};
endpackage

// ---- tb/core_seq_model.sv ----
// Stand-in for the core sequencer: machine-cycle and boundary strobes
// Assumes one core clock and a synchronous active-high reset
`timescale 1ns/1ps
module core_seq_model #(
	parameter int CLK_PER_MC = 4 // Core clocks per machine cycle
) (
	input  wire logic clk_i,      // Core clock
	input  wire logic rst_i,      // Sync reset, active high
	output logic      mcycle_o,   // One-cycle machine-cycle strobe
	output logic      instr_end_o // Instruction boundary
);
	// ------------------------------------------------------------
	// Strobe generation
	// ------------------------------------------------------------
	logic [7:0] cnt;

	// Every instruction lasts one machine cycle, the fastest response
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt      <= 8'h00;
			mcycle_o <= 1'b0;
		end
		else
		begin
			cnt      <= (cnt == 8'(CLK_PER_MC - 1)) ? 8'h00 : cnt + 8'h01;
			mcycle_o <= (cnt == 8'(CLK_PER_MC - 1));
		end
	end

	// Boundary rides on each strobe, so no request waits for an opcode
	assign instr_end_o = mcycle_o;
endmodule // core_seq_model

// ---- tb/tb_cpu_interrupt_controller.sv ----
// Self-checking bench of the interrupt controller
// Assumes the sequencer stand-in drives the machine-cycle strobes
`timescale 1ns/1ps
module tb_cpu_interrupt_controller;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic        clk_i, rst_i, sfr_wr_i, sfr_rd_i, return_from_irq_instr_i;
	logic [7:0]  sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
	logic        mcycle_i, instr_end_i, user_io_hi_n_i, user_io_lo_n_i;
	logic        irq_pin_a_i, irq_pin_b_i, t0_ovf_i, t1_ovf_i;
	logic        s0_req_i, s1_req_i, force_call_o, vector_entry_o;
	logic [3:0]  ext4_src_i, ext4_mask_i, ext5_src_i, ext5_mask_i;
	logic [3:0]  ext6_src_i, ext6_mask_i, in_service_o;
	logic [15:0] vector_o;
	int          fails, n_tests, cycles;
	typedef struct { int src; logic [15:0] vec; } row_s;
	// Source codes follow the polling order, each with its vector
	row_s rows [11] = '{'{0, 16'h0003}, '{1, 16'h0083}, '{2, 16'h000B},
		'{3, 16'h004B}, '{4, 16'h0013}, '{5, 16'h0053}, '{6, 16'h001B},
		'{7, 16'h0023}, '{8, 16'h005B}, '{9, 16'h0063}, '{10, 16'h006B}};
	logic [7:0] regs [9] = '{8'h88, 8'h9A, 8'hA8, 8'hB8, 8'hC0, 8'hC8,
		8'hA9, 8'hB9, 8'h90};

	cpu_interrupt_controller DUT (.clk_i(clk_i), .rst_i(rst_i),
		.sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
		.sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o),
		.mcycle_i(mcycle_i), .instr_end_i(instr_end_i),
		.return_from_irq_instr_i(return_from_irq_instr_i),
		.user_io_hi_n_i(user_io_hi_n_i), .user_io_lo_n_i(user_io_lo_n_i),
		.irq_pin_a_i(irq_pin_a_i), .irq_pin_b_i(irq_pin_b_i),
		.ext4_src_i(ext4_src_i), .ext4_mask_i(ext4_mask_i),
		.ext5_src_i(ext5_src_i), .ext5_mask_i(ext5_mask_i),
		.ext6_src_i(ext6_src_i), .ext6_mask_i(ext6_mask_i),
		.t0_ovf_i(t0_ovf_i), .t1_ovf_i(t1_ovf_i), .s0_req_i(s0_req_i),
		.s1_req_i(s1_req_i), .force_call_o(force_call_o),
		.vector_entry_o(vector_entry_o), .vector_o(vector_o),
		.in_service_o(in_service_o));
	core_seq_model #(.CLK_PER_MC(4)) u_seq (.clk_i(clk_i), .rst_i(rst_i),
		.mcycle_o(mcycle_i), .instr_end_o(instr_end_i));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic check(input string nm, input logic [15:0] seen, exp);
		n_tests++;
		if (seen !== exp)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic sfr_write(input logic [7:0] a, d);
		@(posedge clk_i);
		sfr_addr_i  <= a;
		sfr_wdata_i <= d;
		sfr_wr_i    <= 1'b1;
		@(posedge clk_i);
		sfr_wr_i    <= 1'b0;
	endtask

	// Read data is registered, so it is looked at the cycle after
	task automatic rd_check(input logic [7:0] a, exp);
		@(posedge clk_i);
		sfr_addr_i <= a;
		sfr_rd_i   <= 1'b1;
		@(posedge clk_i);
		sfr_rd_i   <= 1'b0;
		#1;
		check("sfr_rdata", {8'h00, sfr_rdata_o}, {8'h00, exp});
	endtask

	// Idle levels; ext2/3 pins rest high so a fall is the active edge
	task automatic rel();
		user_io_hi_n_i <= 1'b1;
		user_io_lo_n_i <= 1'b1;
		irq_pin_a_i    <= 1'b1;
		irq_pin_b_i    <= 1'b1;
		s0_req_i       <= 1'b0;
		s1_req_i       <= 1'b0;
		ext4_src_i     <= 4'h0;
		ext5_src_i     <= 4'h0;
		ext6_src_i     <= 4'h0;
	endtask

	// Source 0x5 with mask 0x3 fires whatever the mask polarity
	task automatic fire(input int s);
		@(posedge clk_i);
		case (s)
			0: user_io_hi_n_i <= 1'b0;
			1: s1_req_i <= 1'b1;
			2: t0_ovf_i <= 1'b1;
			3: irq_pin_a_i <= 1'b0;
			4: user_io_lo_n_i <= 1'b0;
			5: irq_pin_b_i <= 1'b0;
			6: t1_ovf_i <= 1'b1;
			7: s0_req_i <= 1'b1;
			8: ext4_src_i <= 4'h5;
			9: ext5_src_i <= 4'h5;
			default: ext6_src_i <= 4'h5;
		endcase
		@(posedge clk_i);
		t0_ovf_i <= 1'b0;
		t1_ovf_i <= 1'b0;
	endtask

	// Waits for handler entry, counting strobes during the forced call
	task automatic serve(input logic [15:0] vec, input logic [3:0] ins);
		int n;
		int mc;
		mc = 0;
		for (n = 0; n < 200; n++)
		begin
			@(posedge clk_i);
			#1;
			if (vector_entry_o === 1'b1)
				break;
			if (force_call_o === 1'b1 && mcycle_i === 1'b1)
				mc++;
		end
		check("entry", {15'h0, vector_entry_o}, 16'h1);
		check("call_mcycles", 16'(mc), 16'h6);
		check("vector", vector_o, vec);
		check("in_service", {12'h0, in_service_o}, {12'h0, ins});
	endtask

	task automatic ret_pulse();
		@(posedge clk_i);
		return_from_irq_instr_i <= 1'b1;
		@(posedge clk_i);
		return_from_irq_instr_i <= 1'b0;
		@(posedge clk_i);
		#1;
	endtask

	// ------------------------------------------------------------
	// Clock, timeout and main sequence
	// ------------------------------------------------------------
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	// The whole run needs some 1000 cycles; a hang is cut at 5000
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			fails++;
			print_verdict();
		end
	end

	initial
	begin
		rst_i = 1'b1;
		sfr_addr_i = 8'h00;
		sfr_wdata_i = 8'h00;
		sfr_wr_i = 1'b0;
		sfr_rd_i = 1'b0;
		return_from_irq_instr_i = 1'b0;
		t0_ovf_i = 1'b0;
		t1_ovf_i = 1'b0;
		ext4_mask_i = 4'h3;
		ext5_mask_i = 4'h3;
		ext6_mask_i = 4'h3;
		rel();
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		sfr_write(8'hA8, 8'h9F);
		sfr_write(8'hB8, 8'h3E);
		sfr_write(8'h9A, 8'h01);
		foreach (rows[i])
		begin
			fire(rows[i].src);
			serve(rows[i].vec, 4'h1);
			@(posedge clk_i);
			rel();
			repeat (12) @(posedge clk_i);
			ret_pulse();
			check("in_service", {12'h0, in_service_o}, 16'h0);
		end
		$display("test sources done");
		// Second reset mid-run clears every SFR register
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (regs[i])
			rd_check(regs[i], 8'h00);
		$display("test reset done");
		// Flags set while every source is disabled
		fire(2);
		fire(6);
		fire(3);
		repeat (12) @(posedge clk_i);
		rd_check(8'h88, 8'hA0);
		rd_check(8'hC0, 8'h02);
		@(posedge clk_i);
		rel();
		$display("test flags done");
		// Global enable off blocks pending timers, then poll order
		sfr_write(8'hA8, 8'h0A);
		repeat (40) @(posedge clk_i);
		#1;
		check("force_call", {15'h0, force_call_o}, 16'h0);
		sfr_write(8'hA8, 8'h8A);
		serve(16'h000B, 4'h1);
		rd_check(8'h88, 8'h80);
		ret_pulse();
		serve(16'h001B, 4'h1);
		ret_pulse();
		$display("test global done");
		// Timer 0 group raised to level 3 preempts a level 0 service
		sfr_write(8'hA9, 8'h02);
		sfr_write(8'hB9, 8'h02);
		sfr_write(8'hA8, 8'h8B);
		fire(0);
		serve(16'h0003, 4'h1);
		@(posedge clk_i);
		rel();
		fire(2);
		serve(16'h000B, 4'h9);
		fire(6);
		repeat (40) @(posedge clk_i);
		#1;
		check("force_call", {15'h0, force_call_o}, 16'h0);
		ret_pulse();
		check("in_service", {12'h0, in_service_o}, 16'h1);
		ret_pulse();
		serve(16'h001B, 4'h1);
		ret_pulse();
		$display("test nesting done");
		// Edge mode on ext0 keeps its flag; ext2 set to the rising edge
		sfr_write(8'hA8, 8'h00);
		sfr_write(8'hC0, 8'h00);
		sfr_write(8'h88, 8'h01);
		sfr_write(8'hC8, 8'h20);
		fire(0);
		fire(3);
		repeat (12) @(posedge clk_i);
		rd_check(8'hC0, 8'h00);
		@(posedge clk_i);
		rel();
		repeat (12) @(posedge clk_i);
		rd_check(8'h88, 8'h03);
		rd_check(8'hC0, 8'h02);
		$display("test edge done");
		print_verdict();
	end
endmodule // tb_cpu_interrupt_controller
